// *** pfc_pkg.sv ***
// Package for the parallel flash host controller.
// Assumes a single core clock; used by pfc_ctrl and the testbench.
package pfc_pkg;
  // Software register offsets of the controller
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_CMD = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RDATA = 4'h5;
  localparam logic [3:0] REG_GROUP = 4'h6;
  // Control register fields
  localparam int CTRL_WORD_BIT = 0;
  localparam int CTRL_BOOT_LOCK_BIT = 1;
  localparam int CTRL_ACCEL_BIT = 2;
  localparam int CTRL_HVPROT_BIT = 3;
  localparam int CTRL_BOTTOM_BIT = 4;
  localparam logic [7:0] CTRL_RESET_VAL = 8'h01;
  // Command codes
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_HW_ID = 3'h3;
  localparam logic [2:0] CMD_PROT_VERIFY = 3'h4;
  localparam logic [2:0] CMD_HW_RESET = 3'h5;
  localparam logic [2:0] CMD_MFR_ID = 3'h6;
  // Timing in ns and cycles at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACCESS_TIME_NS = 90;
  localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_NS = 35;
  localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_NS = 500;
  localparam int RESET_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_NS = 50;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Address width, protection group count and protected verify code
  localparam int ADDR_W = 22;
  localparam int GROUPS = 40;
  localparam logic [7:0] PROTECTED_CODE = 8'h01;
  typedef enum logic [2:0] {
    PFC_IDLE = 3'b000,
    PFC_READ = 3'b001,
    PFC_WRITE = 3'b010,
    PFC_RESET = 3'b011,
    PFC_RECOVER = 3'b100
  } pfc_state_e;
endpackage

// *** pfc_grp_mem.sv ***
// Small memory of per-group protection flags seen by verify reads.
// Assumes one writer and one reader port on the core clock.
`timescale 1ns/1ps
module pfc_grp_mem #(
  parameter int DEPTH = 40
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Write port
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic wr_data,
  // Read port
  input wire logic [5:0] rd_addr,
  output logic rd_data
);
  initial begin
    if (DEPTH < 1 || DEPTH > 64) begin
      $error("pfc_grp_mem depth out of range");
    end
  end
  logic [DEPTH-1:0] flags_ff;
  logic rd_ff;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_ff <= '0;
      rd_ff <= 1'b0;
    end else begin
      if (wr_en && wr_addr < 6'(DEPTH)) begin
        flags_ff[wr_addr] <= wr_data;
      end
      rd_ff <= (rd_addr < 6'(DEPTH)) ? flags_ff[rd_addr] : 1'b0;
    end
  end
  assign rd_data = rd_ff;
endmodule

// *** pfc_ctrl.sv ***
// Host-side controller driving an asynchronous parallel NOR flash.
// Assumes flash pins are sampled synchronously; high voltage levels are
// requested through level-select outputs handled by board drivers.
// Behaviour
// - Host writes reset command when timeout flag high or in autoselect.
// - Hardware autoselect: high voltage on select line, protect bit low.
// - Protection verify: sector on top bits, addr bit1 high, bit0 low.
// - Manufacturer read holds address bit eight high.
// - Autoselect codes also reachable by command sequence at logic levels.
// - Command writes drive write and chip select low, output enable high.
// - Reset pin at high voltage enables in-system protection method.
// - Protect all unprotected groups before any chip unprotect write.
// - Programmer method needs high voltage on output enable and select.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module pfc_ctrl #(
  parameter int RESET_CYCLES = pfc_pkg::RESET_CYC,
  parameter int ACCESS_CYCLES = pfc_pkg::ACCESS_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Software register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Flash control pins
  output logic chip_select_low,
  output logic output_enable_low,
  output logic write_strobe_low,
  output logic width_select_n,
  output logic hw_reset_low,
  output logic boot_lock_accel_pin,
  // High voltage requests for board drivers
  output logic hv_select_line,
  output logic hv_reset_level,
  output logic accel_level,
  // Flash address and data
  output logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic [15:0] flash_dq_oe
);
  initial begin
    if (RESET_CYCLES < 1 || RESET_CYCLES > 65535 || ACCESS_CYCLES < 1 ||
        ACCESS_CYCLES > 65535) begin
      $error("pfc_ctrl cycle counts out of range");
    end
  end

  typedef struct packed {
    pfc_pkg::pfc_state_e state;
    logic [15:0] cnt;
    logic [7:0] ctrl;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic busy;
    logic autoselect;
    logic timeout_seen;
    logic verify_pending;
    logic [5:0] verify_group;
    logic [31:0] rd_out;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic hv_sel;
    logic [15:0] dq_out;
    logic [15:0] dq_oe;
  } pfc_regs_s;

  pfc_regs_s cur_ff;
  pfc_regs_s nxt_st;
  logic grp_rd;

  // Group index from the upper address bits of either boot layout
  function automatic logic [5:0] grp_of(input logic [21:0] a, input logic bottom);
    logic [9:0] up;
    logic [5:0] g;
    up = a[21:12];
    g = 6'h00;
    if (bottom) begin
      if (up[9:3] == 7'h00) begin
        g = {3'h0, up[2:0]};
      end else if (up[9:5] == 5'h00) begin
        g = 6'h08;
      end else begin
        g = 6'(up[9:5]) + 6'h08;
      end
    end else begin
      if (up[9:3] == 7'h7f) begin
        g = 6'h20 + {3'h0, up[2:0]};
      end else if (up[9:5] == 5'h1f) begin
        g = 6'h1f;
      end else begin
        g = {1'b0, up[9:5]};
      end
    end
    return g;
  endfunction

  pfc_grp_mem #(
    .DEPTH(pfc_pkg::GROUPS)
  ) u_grp (
    .core_clk(core_clk),
    .reset(reset),
    .wr_en(cur_ff.verify_pending),
    .wr_addr(cur_ff.verify_group),
    .wr_data(cur_ff.rdata[7:0] == pfc_pkg::PROTECTED_CODE),
    // Lookup follows the group of the current address, one cycle behind it
    .rd_addr(grp_of(cur_ff.addr, cur_ff.ctrl[pfc_pkg::CTRL_BOTTOM_BIT])),
    .rd_data(grp_rd)
  );

  always_comb begin
    logic word;
    logic [2:0] cmd;
    word = 1'b0;
    cmd = reg_wdata[2:0];
    nxt_st = cur_ff;
    nxt_st.verify_pending = 1'b0;
    word = cur_ff.ctrl[pfc_pkg::CTRL_WORD_BIT];
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        pfc_pkg::REG_CTRL: nxt_st.ctrl = reg_wdata[7:0];
        pfc_pkg::REG_ADDR: nxt_st.addr = reg_wdata[21:0];
        pfc_pkg::REG_WDATA: nxt_st.wdata = reg_wdata[15:0];
        default: ;
      endcase
    end
    nxt_st.rd_out = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        pfc_pkg::REG_CTRL: nxt_st.rd_out = {24'h0, cur_ff.ctrl};
        pfc_pkg::REG_ADDR: nxt_st.rd_out = {10'h0, cur_ff.addr};
        pfc_pkg::REG_WDATA: nxt_st.rd_out = {16'h0, cur_ff.wdata};
        pfc_pkg::REG_STATUS: nxt_st.rd_out = {28'h0, cur_ff.timeout_seen,
          cur_ff.autoselect, 1'b0, cur_ff.busy};
        pfc_pkg::REG_RDATA: nxt_st.rd_out = {16'h0, cur_ff.rdata};
        pfc_pkg::REG_GROUP: nxt_st.rd_out = {25'h0, grp_rd,
          grp_of(cur_ff.addr, cur_ff.ctrl[pfc_pkg::CTRL_BOTTOM_BIT])};
        default: nxt_st.rd_out = 32'h0;
      endcase
    end
    case (cur_ff.state)
      pfc_pkg::PFC_IDLE: begin
        nxt_st.cnt = 16'h0;
        nxt_st.busy = 1'b0;
        nxt_st.cs_n = 1'b1;
        nxt_st.oe_n = 1'b1;
        nxt_st.we_n = 1'b1;
        nxt_st.hv_sel = 1'b0;
        nxt_st.dq_oe = 16'h0;
        if (reg_wr && reg_addr == pfc_pkg::REG_CMD) begin
          nxt_st.busy = 1'b1;
          case (cmd)
            pfc_pkg::CMD_READ: begin
              nxt_st.state = pfc_pkg::PFC_READ;
              nxt_st.cs_n = 1'b0;
              nxt_st.oe_n = 1'b0;
            end
            pfc_pkg::CMD_WRITE: begin
              // Write strobe with output enable held high
              nxt_st.state = pfc_pkg::PFC_WRITE;
              nxt_st.cs_n = 1'b0;
              nxt_st.we_n = 1'b0;
              // Byte mode puts the low address bit on the top data line
              nxt_st.dq_out = word ? cur_ff.wdata : {cur_ff.addr[0], 7'h0,
                cur_ff.wdata[7:0]};
              nxt_st.dq_oe = word ? 16'hffff : 16'h80ff;
              // Reset command clears tracked autoselect and timeout
              if (cur_ff.wdata[7:0] == 8'hf0) begin
                nxt_st.autoselect = 1'b0;
                nxt_st.timeout_seen = 1'b0;
              end else if (cur_ff.wdata[7:0] == 8'h90) begin
                nxt_st.autoselect = 1'b1;
              end
            end
            pfc_pkg::CMD_HW_ID, pfc_pkg::CMD_PROT_VERIFY, pfc_pkg::CMD_MFR_ID: begin
              nxt_st.state = pfc_pkg::PFC_READ;
              nxt_st.cs_n = 1'b0;
              nxt_st.oe_n = 1'b0;
              nxt_st.hv_sel = 1'b1;
              nxt_st.addr[6] = 1'b0;
              nxt_st.verify_group = grp_of(cur_ff.addr,
                cur_ff.ctrl[pfc_pkg::CTRL_BOTTOM_BIT]);
              if (cmd == pfc_pkg::CMD_PROT_VERIFY) begin
                nxt_st.addr[1:0] = 2'b10;
              end else if (cmd == pfc_pkg::CMD_MFR_ID) begin
                nxt_st.addr[8] = 1'b1;
                nxt_st.addr[1:0] = 2'b00;
              end
            end
            pfc_pkg::CMD_HW_RESET: begin
              nxt_st.state = pfc_pkg::PFC_RESET;
              nxt_st.rst_n = 1'b0;
            end
            // No unprotect or programmer-timing cycle is ever issued
            default: nxt_st.busy = 1'b0;
          endcase
        end
      end
      pfc_pkg::PFC_READ: begin
        // Hold address until data has settled, then sample
        nxt_st.cnt = cur_ff.cnt + 16'h1;
        if (cur_ff.cnt >= 16'(ACCESS_CYCLES - 1)) begin
          nxt_st.rdata = word ? flash_dq_in : {8'h0, flash_dq_in[7:0]};
          // Identifier reads carry no status bits
          if (flash_dq_in[5] && !cur_ff.hv_sel && !cur_ff.autoselect) begin
            nxt_st.timeout_seen = 1'b1;
          end
          nxt_st.verify_pending = cur_ff.hv_sel && cur_ff.addr[1:0] == 2'b10 &&
            !cur_ff.addr[6];
          nxt_st.state = pfc_pkg::PFC_RECOVER;
          nxt_st.cnt = 16'h0;
          nxt_st.cs_n = 1'b1;
          nxt_st.oe_n = 1'b1;
          nxt_st.hv_sel = 1'b0;
        end
      end
      pfc_pkg::PFC_WRITE: begin
        nxt_st.cnt = cur_ff.cnt + 16'h1;
        if (cur_ff.cnt >= 16'(pfc_pkg::WRITE_CYC - 1)) begin
          // Flash latches on the rising strobe, so select and data hold a cycle more
          nxt_st.we_n = 1'b1;
          nxt_st.state = pfc_pkg::PFC_RECOVER;
          nxt_st.cnt = 16'h0;
        end
      end
      pfc_pkg::PFC_RESET: begin
        // Flash drops any half-written command during the pulse
        nxt_st.cnt = cur_ff.cnt + 16'h1;
        if (cur_ff.cnt >= 16'(RESET_CYCLES - 1)) begin
          nxt_st.rst_n = 1'b1;
          nxt_st.autoselect = 1'b0;
          nxt_st.timeout_seen = 1'b0;
          nxt_st.state = pfc_pkg::PFC_RECOVER;
          nxt_st.cnt = 16'h0;
        end
      end
      pfc_pkg::PFC_RECOVER: begin
        // Release the bus one cycle after the write strobe rose
        nxt_st.cs_n = 1'b1;
        nxt_st.oe_n = 1'b1;
        nxt_st.dq_oe = 16'h0;
        nxt_st.cnt = cur_ff.cnt + 16'h1;
        if (cur_ff.cnt >= 16'(pfc_pkg::RECOVER_CYC - 1)) begin
          nxt_st.state = pfc_pkg::PFC_IDLE;
          nxt_st.busy = 1'b0;
        end
      end
      default: nxt_st.state = pfc_pkg::PFC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cur_ff <= '0;
      cur_ff.state <= pfc_pkg::PFC_IDLE;
      cur_ff.ctrl <= pfc_pkg::CTRL_RESET_VAL;
      cur_ff.cs_n <= 1'b1;
      cur_ff.oe_n <= 1'b1;
      cur_ff.we_n <= 1'b1;
      cur_ff.rst_n <= 1'b1;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = cur_ff.rd_out;
  assign chip_select_low = cur_ff.cs_n;
  assign output_enable_low = cur_ff.oe_n;
  assign write_strobe_low = cur_ff.we_n;
  assign width_select_n = cur_ff.ctrl[pfc_pkg::CTRL_WORD_BIT];
  assign hw_reset_low = cur_ff.rst_n;
  assign boot_lock_accel_pin = cur_ff.ctrl[pfc_pkg::CTRL_BOOT_LOCK_BIT];
  assign accel_level = cur_ff.ctrl[pfc_pkg::CTRL_ACCEL_BIT];
  assign hv_reset_level = cur_ff.ctrl[pfc_pkg::CTRL_HVPROT_BIT];
  assign hv_select_line = cur_ff.hv_sel;
  assign flash_addr = cur_ff.addr;
  assign flash_dq_out = cur_ff.dq_out;
  assign flash_dq_oe = cur_ff.dq_oe;
endmodule

// *** pfc_ctrl_assertions.sv ***
// Pin protocol checker for the flash host controller.
// Assumes it is bound onto pfc_ctrl and sees only its ports.
`timescale 1ns/1ps
module pfc_ctrl_chk #(
  parameter int RESET_CYCLES = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Flash pins
  input wire logic chip_select_low,
  input wire logic output_enable_low,
  input wire logic write_strobe_low,
  input wire logic width_select_n,
  input wire logic hw_reset_low,
  input wire logic hv_select_line,
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_oe
);
  logic [7:0] low_cnt_ff;
  logic [7:0] nxt_low_cnt;
  assign nxt_low_cnt = hw_reset_low ? 8'h00 : low_cnt_ff + 8'h01;
  always_ff @(posedge core_clk) begin
    low_cnt_ff <= reset ? 8'h00 : nxt_low_cnt;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_cmd_strobes:
    assert property (!write_strobe_low |-> !chip_select_low && output_enable_low)
    else $error("write strobe without select or with output enable");
  a_write_length:
    assert property ($fell(write_strobe_low) |-> !write_strobe_low[*4] ##1 write_strobe_low)
    else $error("write strobe not four cycles");
  a_read_no_drive:
    assert property (!output_enable_low |-> flash_dq_oe == 16'h0000)
    else $error("data driven while flash outputs enabled");
  a_byte_float:
    assert property (!width_select_n |-> flash_dq_oe[14:8] == 7'h00)
    else $error("middle data lines driven in byte mode");
  a_id_prot_bit:
    assert property (hv_select_line |-> !flash_addr[6])
    else $error("protect select bit high during identify");
  a_mfr_bit_eight:
    assert property (hv_select_line && flash_addr[1:0] == 2'b00 |-> flash_addr[8])
    else $error("maker code read with address bit eight low");
  a_reset_quiet:
    assert property (!hw_reset_low |-> write_strobe_low && flash_dq_oe == 16'h0000)
    else $error("bus active during flash reset");
  a_reset_pulse:
    assert property ($rose(hw_reset_low) |-> low_cnt_ff == RESET_CYCLES)
    else $error("flash reset pulse has wrong length");
  a_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule

bind pfc_ctrl pfc_ctrl_chk #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.core_clk(core_clk),
  .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_select_low(chip_select_low),
  .output_enable_low(output_enable_low), .write_strobe_low(write_strobe_low),
  .width_select_n(width_select_n), .hw_reset_low(hw_reset_low),
  .hv_select_line(hv_select_line), .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe));

// *** pfc_flash_model.sv ***
// Behavioural parallel flash facing the controller pins.
// Assumes core_clk only ages the pattern shown on released lines.
`timescale 1ns/1ps
module pfc_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h5e, // arbitrary value
  parameter logic [7:0] CFG_CODE = 8'h6d, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h4a3b // arbitrary value
) (
  // Clock
  input wire logic core_clk,
  // Bus pins
  input wire logic chip_select_low,
  input wire logic output_enable_low,
  input wire logic write_strobe_low,
  input wire logic width_select_n,
  input wire logic hw_reset_low,
  input wire logic hv_select_line,
  input wire logic boot_lock_accel_pin,
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic [15:0] flash_dq_oe,
  output logic [15:0] flash_dq_in,
  // Last accepted write
  output logic [15:0] wr_data,
  output logic [21:0] wr_addr
);
  logic tgl = 1'b0;
  logic asel = 1'b0;
  logic [15:0] flt;
  logic [15:0] val;
  logic boot_blocked;
  // Top-boot layout: the two outermost small sectors sit at the very top
  assign boot_blocked = !boot_lock_accel_pin && flash_addr[21:13] == 9'h1ff;
  always @(posedge core_clk) tgl <= ~tgl;
  // Released lines toggle so stale data never looks valid
  assign flt = {8{tgl, ~tgl}};
  always @(posedge write_strobe_low) begin
    if (!chip_select_low && hw_reset_low && !boot_blocked) begin
      wr_data = flash_dq_out & flash_dq_oe;
      wr_addr = flash_addr;
      if (wr_data[7:0] == 8'h90) asel = 1'b1;
      if (wr_data[7:0] == 8'hf0) asel = 1'b0;
    end
  end
  always @(negedge hw_reset_low) asel = 1'b0;
  always_comb begin
    val = flash_addr[15:0] ^ 16'h3c3c;
    if (hv_select_line || asel) begin
      case (flash_addr[1:0])
        2'b00: val = {8'h00, flash_addr[8] ? MFR_CODE : CFG_CODE};
        2'b01: val = DEV_CODE;
        default: val = {15'h0, flash_addr[21:17] == 5'd5};
      endcase
    end
    if (!width_select_n) val[15:8] = flt[15:8];
    flash_dq_in = val;
    if (chip_select_low || output_enable_low || !hw_reset_low) begin
      flash_dq_in = flt;
    end
  end
endmodule

// *** testbench.sv ***
// Self-checking bench for the flash host controller.
// Assumes the flash model answers on the far side of the pins.
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] MFR = 8'h5e;
  localparam logic [15:0] DEV = 16'h4a3b;
  logic core_clk;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic chip_select_low, output_enable_low, write_strobe_low, width_select_n;
  logic hw_reset_low, boot_lock_accel_pin, hv_select_line, hv_reset_level, accel_level;
  logic [21:0] flash_addr, m_wr_addr;
  logic [15:0] flash_dq_in, flash_dq_out, flash_dq_oe, m_wr_data;
  int failures = 0;
  int total_checks = 0;
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); \
  end \
end
  pfc_ctrl #(.RESET_CYCLES(2), .ACCESS_CYCLES(2)) DUT (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .chip_select_low(chip_select_low),
    .output_enable_low(output_enable_low), .write_strobe_low(write_strobe_low),
    .width_select_n(width_select_n), .hw_reset_low(hw_reset_low),
    .boot_lock_accel_pin(boot_lock_accel_pin), .hv_select_line(hv_select_line),
    .hv_reset_level(hv_reset_level), .accel_level(accel_level), .flash_addr(flash_addr),
    .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
  pfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.core_clk(core_clk),
    .chip_select_low(chip_select_low), .output_enable_low(output_enable_low),
    .write_strobe_low(write_strobe_low), .width_select_n(width_select_n),
    .hw_reset_low(hw_reset_low), .hv_select_line(hv_select_line),
    .boot_lock_accel_pin(boot_lock_accel_pin), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
    .wr_data(m_wr_data), .wr_addr(m_wr_addr));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic summarize();
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic cmd(input logic [2:0] c);
    logic [31:0] s;
    wr(pfc_pkg::REG_CMD, {29'h0, c});
    for (int i = 0; i < 40; i++) begin
      rd(pfc_pkg::REG_STATUS, s);
      if (s[0] === 1'b0) break;
    end
    `CHK(s[0], 1'b0)
  endtask
  task automatic op(input logic [2:0] c, input logic [21:0] a, input logic [15:0] w,
                    output logic [31:0] d);
    wr(pfc_pkg::REG_ADDR, {10'h0, a});
    wr(pfc_pkg::REG_WDATA, {16'h0, w});
    cmd(c);
    rd(pfc_pkg::REG_RDATA, d);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    @(posedge core_clk);
    #1;
    `CHK({chip_select_low, write_strobe_low, hw_reset_low}, 3'h7)
    `CHK(flash_dq_oe, 16'h0000)
    rd(pfc_pkg::REG_CTRL, d);
    `CHK(d, 32'h1)
    `CHK(width_select_n, 1'b1)
    rd(4'hf, d);
    `CHK(d, 32'h0)
  endtask
  task automatic t_ctrl();
    logic [31:0] d;
    wr(pfc_pkg::REG_CTRL, 32'h0e);
    @(posedge core_clk);
    #1;
    `CHK({boot_lock_accel_pin, accel_level, hv_reset_level, width_select_n}, 4'he)
    rd(pfc_pkg::REG_CTRL, d);
    `CHK(d, 32'h0e)
    wr(pfc_pkg::REG_CTRL, 32'h01);
  endtask
  task automatic t_write();
    logic [31:0] d;
    op(pfc_pkg::CMD_WRITE, 22'h15a5a5, 16'hc3e1, d);
    `CHK(m_wr_data, 16'hc3e1)
    `CHK(m_wr_addr, 22'h15a5a5)
    op(pfc_pkg::CMD_WRITE, 22'h3ff000, 16'h5a5a, d);
    `CHK(m_wr_addr, 22'h15a5a5)
    wr(pfc_pkg::REG_CTRL, 32'h00);
    op(pfc_pkg::CMD_WRITE, 22'h3, 16'h12a7, d);
    `CHK(m_wr_data, 16'h80a7)
    op(pfc_pkg::CMD_READ, 22'h3, 16'h0, d);
    `CHK(d[7:0], 8'h3f)
    wr(pfc_pkg::REG_CTRL, 32'h01);
  endtask
  task automatic t_ident();
    logic [31:0] d;
    op(pfc_pkg::CMD_HW_ID, 22'h1, 16'h0, d);
    `CHK(d[15:0], DEV)
    op(pfc_pkg::CMD_MFR_ID, 22'h0, 16'h0, d);
    `CHK(d[7:0], MFR)
    op(pfc_pkg::CMD_PROT_VERIFY, 22'h0a0000, 16'h0, d);
    `CHK(d[7:0], 8'h01)
    rd(pfc_pkg::REG_GROUP, d);
    `CHK(d[6:0], 7'h45)
    op(pfc_pkg::CMD_PROT_VERIFY, 22'h0c0000, 16'h0, d);
    `CHK(d[7:0], 8'h00)
    rd(pfc_pkg::REG_GROUP, d);
    `CHK(d[6:0], 7'h06)
    wr(pfc_pkg::REG_CTRL, 32'h11);
    wr(pfc_pkg::REG_ADDR, 32'h003c0000);
    rd(pfc_pkg::REG_GROUP, d);
    `CHK(d[6:0], 7'h26)
    wr(pfc_pkg::REG_ADDR, 32'h00012000);
    rd(pfc_pkg::REG_GROUP, d);
    `CHK(d[6:0], 7'h08)
    wr(pfc_pkg::REG_CTRL, 32'h01);
  endtask
  task automatic t_modes();
    logic [31:0] d;
    int n;
    n = 0;
    op(pfc_pkg::CMD_READ, 22'h2abcd5, 16'h0, d);
    `CHK(d[15:0], 16'h80e9)
    rd(pfc_pkg::REG_STATUS, d);
    `CHK(d[3], 1'b1)
    op(pfc_pkg::CMD_WRITE, 22'h555, 16'hf0, d);
    rd(pfc_pkg::REG_STATUS, d);
    `CHK(d[3:2], 2'b00)
    op(pfc_pkg::CMD_WRITE, 22'h555, 16'h90, d);
    rd(pfc_pkg::REG_STATUS, d);
    `CHK(d[2], 1'b1)
    op(pfc_pkg::CMD_READ, 22'h1, 16'h0, d);
    `CHK(d[15:0], DEV)
    fork
      cmd(pfc_pkg::CMD_HW_RESET);
      repeat (30) begin
        @(posedge core_clk);
        #1 if (hw_reset_low === 1'b0) n++;
      end
    join
    `CHK(n, 2)
    op(pfc_pkg::CMD_READ, 22'h1, 16'h0, d);
    `CHK(d[15:0], 16'h3c3d)
  endtask
  // Whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_ctrl();
    t_write();
    t_ident();
    t_modes();
    summarize();
  end
endmodule
